// ===== rtl/dram_host_pkg.sv
// package: timing constants and enumerations for the refresh host controller
package dram_host_pkg;
   localparam int CLK_PERIOD_NS      = 25;
   localparam int POWERUP_PAUSE_US   = 100;
   localparam int POWERUP_CYC        =
      (POWERUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_STROBES       = 8;
   localparam int REFRESH_INTERVAL_US = 62;
   localparam int REFRESH_CYC        = (REFRESH_INTERVAL_US * 1000) / CLK_PERIOD_NS;
   localparam int REFRESH_SLACK_CYC  = 16;
   localparam int SR_PERIOD_MIN_NS   = 1000;
   localparam int SR_PERIOD_MAX_US   = 5;
   localparam int SR_PERIOD_CYC      = (SR_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SR_PERIOD_MAX_CYC  = (SR_PERIOD_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int ROW_PRECHARGE_NS   = 390;
   localparam int PRECHARGE_CYC      = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_PULSE_NS       = 600;
   localparam int PULSE_CYC          = (ROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_SETUP_NS       = 30;
   localparam int COL_SETUP_CYC      = (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_LEAD_NS        = 200;
   localparam int REQ_LEAD_CYC       = (REQ_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W              = 13;
   localparam int ROW_COUNT          = 512;
   localparam int ROW_W              = 9;
   typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_LOW, PH_HIGH} phase_type;
   typedef enum logic [2:0] {
      ST_PAUSE, ST_INIT, ST_READY, ST_ORD_REF, ST_ACCESS, ST_SR_ENTER, ST_SR, ST_SR_EXIT
   } state_type;
endpackage

// ===== rtl/dram_refresh_host.sv
// module: host controller for power-up, refresh and self-refresh of a 1M x 1 dram
// -----------------------------------------------
// Overview of operation
// R01 - after power-up hold strobes high 100 us, then eight row cycles
// R02 - device's own counter feeds both refresh kinds; host mirrors it
// R03 - host issues a strobe-order refresh at least every 62 us
// R04 - other refresh methods need burst refresh around self-refresh; not used
// R05 - after self-refresh, first strobe-order refresh within max strobe period
// R06 - before self-refresh, last strobe-order refresh within max strobe period
// R07 - gap between self-refresh periods bounded when no refresh intervenes
// R08 - self-refresh row strobe period at least 1000 ns, at most 5 us
// R09 - early write data is taken at the column strobe falling edge
// R10 - device self-refreshes while request low and row strobe toggles
// R11 - strobe-order refresh: column strobe falls before row strobe and stays low
// R12 - all 512 rows refreshed within each 32 ms
// R13 - write strobe high reads, low writes
// R14 - refresh row counter is nine bits and wraps to zero
// -----------------------------------------------
`timescale 1ns/1ps
module dram_refresh_host
   import dram_host_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             selfRefreshReq,
   input  wire logic             accessReq,
   output logic                  rowStrobeN_ff,
   output logic                  colStrobeN_ff,
   output logic                  self_refresh_request_n_ff,
   output logic                  writeStrobeN_ff,
   output logic                  ready_ff,
   output logic                  inSelfRefresh_ff,
   output logic [ROW_W-1:0]      refreshRow_ff
);
   state_type           state_ff;
   logic [CNT_W-1:0]    waitCnt_ff;
   logic [CNT_W-1:0]    refCnt_ff;
   logic [3:0]          initCnt_ff;
   logic                srReqSync1_ff;
   logic                srReqSync2_ff;
   logic                accSync1_ff;
   logic                accSync2_ff;
   logic                refDue;
   logic                seqRow;
   logic                seqCol;

   strobe_if sq ();

   strobe_seq u_seq (
      .mclk          (mclk),
      .rst           (rst),
      .req           (sq.seq),
      .rowStrobeN_ff (seqRow),
      .colStrobeN_ff (seqCol)
   );

   // -----------------------------------------------
   // input synchronisers
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         srReqSync1_ff <= 1'b0;
         srReqSync2_ff <= 1'b0;
         accSync1_ff   <= 1'b0;
         accSync2_ff   <= 1'b0;
      end else begin
         srReqSync1_ff <= selfRefreshReq;
         srReqSync2_ff <= srReqSync1_ff;
         accSync1_ff   <= accessReq;
         accSync2_ff   <= accSync1_ff;
      end
   end

   // -----------------------------------------------
   // refresh interval timer
   // -----------------------------------------------
   // margin for an access already in flight plus the refresh's own lead-in,
   // so the gap between two refresh row falls never passes the interval
   assign refDue = (refCnt_ff >=
                    CNT_W'(REFRESH_CYC - 2 * SR_PERIOD_CYC - REFRESH_SLACK_CYC)); // R03

   always_ff @(posedge mclk) begin
      if (rst || state_ff != ST_READY && state_ff != ST_ACCESS) begin
         refCnt_ff <= '0;
      end else if (!refDue) begin
         refCnt_ff <= refCnt_ff + 1'b1;
      end
   end

   // -----------------------------------------------
   // mirrored row counter
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         refreshRow_ff <= '0;
      // the pulse after release runs with the request high and takes no counter row
      end else if (sq.done && state_ff inside {ST_ORD_REF, ST_SR_ENTER, ST_SR}) begin
         refreshRow_ff <= refreshRow_ff + 1'b1; // R02 R14
      end
   end

   // -----------------------------------------------
   // main sequencer
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff                  <= ST_PAUSE;
         waitCnt_ff                <= '0;
         initCnt_ff                <= '0;
         sq.start                  <= 1'b0;
         sq.colFirst               <= 1'b0;
         self_refresh_request_n_ff <= 1'b1;
         writeStrobeN_ff           <= 1'b1;
         ready_ff                  <= 1'b0;
         inSelfRefresh_ff          <= 1'b0;
      end else begin
         sq.start <= 1'b0;
         unique case (state_ff)
            ST_PAUSE: begin
               waitCnt_ff <= waitCnt_ff + 1'b1;
               if (waitCnt_ff == CNT_W'(POWERUP_CYC - 1)) begin // R01
                  state_ff <= ST_INIT;
               end
            end
            ST_INIT: begin
               if (!sq.busy && !sq.start) begin
                  if (initCnt_ff == 4'(INIT_STROBES)) begin // R01
                     state_ff <= ST_READY;
                     ready_ff <= 1'b1;
                  end else begin
                     sq.start    <= 1'b1;
                     sq.colFirst <= 1'b0;
                     initCnt_ff  <= initCnt_ff + 1'b1;
                  end
               end
            end
            ST_READY: begin
               if (refDue || srReqSync2_ff) begin
                  sq.start    <= 1'b1;
                  sq.colFirst <= 1'b1; // R03 R04 R06
                  ready_ff    <= 1'b0;
                  state_ff    <= srReqSync2_ff ? ST_SR_ENTER : ST_ORD_REF;
               end else if (accSync2_ff) begin
                  sq.start        <= 1'b1;
                  sq.colFirst     <= 1'b0;
                  writeStrobeN_ff <= 1'b1; // R13
                  state_ff        <= ST_ACCESS;
               end
            end
            ST_ORD_REF, ST_ACCESS: begin
               if (sq.done) begin
                  ready_ff <= 1'b1;
                  state_ff <= ST_READY;
               end
            end
            ST_SR_ENTER: begin
               if (sq.done) begin
                  self_refresh_request_n_ff <= 1'b0; // R10
                  inSelfRefresh_ff          <= 1'b1;
                  waitCnt_ff                <= '0;
                  state_ff                  <= ST_SR;
               end
            end
            ST_SR: begin
               if (!sq.busy && !sq.start) begin
                  waitCnt_ff <= waitCnt_ff + 1'b1;
                  if (waitCnt_ff >= CNT_W'(REQ_LEAD_CYC)) begin
                     sq.start    <= 1'b1;
                     sq.colFirst <= 1'b0; // R08 R10
                     waitCnt_ff  <= '0;
                     if (!srReqSync2_ff) begin
                        self_refresh_request_n_ff <= 1'b1;
                        state_ff                  <= ST_SR_EXIT;
                     end
                  end
               end
            end
            ST_SR_EXIT: begin
               if (sq.done) begin
                  sq.start         <= 1'b1;
                  sq.colFirst      <= 1'b1; // R05 R07
                  inSelfRefresh_ff <= 1'b0;
                  state_ff         <= ST_ORD_REF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rowStrobeN_ff <= 1'b1;
         colStrobeN_ff <= 1'b1;
      end else begin
         rowStrobeN_ff <= seqRow;
         colStrobeN_ff <= seqCol;
      end
   end

   // -----------------------------------------------
   // checks
   // -----------------------------------------------
   a_pause_strobes_high: assert property (@(posedge mclk) disable iff (rst)
      state_ff == ST_PAUSE |-> rowStrobeN_ff && colStrobeN_ff && self_refresh_request_n_ff) // R01
      else $error("strobe low during power-up pause");
   a_refresh_on_time: assert property (@(posedge mclk) disable iff (rst)
      state_ff == ST_READY && refDue |=> sq.start && sq.colFirst) // R03
      else $error("due refresh not started");
   a_row_wraps: assert property (@(posedge mclk) disable iff (rst)
      refreshRow_ff == ROW_W'(ROW_COUNT - 1) && sq.done
         && state_ff inside {ST_ORD_REF, ST_SR_ENTER, ST_SR} |=> refreshRow_ff == '0) // R14
      else $error("row counter did not wrap");
   a_sr_req_quiet: assert property (@(posedge mclk) disable iff (rst)
      $fell(self_refresh_request_n_ff) |-> rowStrobeN_ff) // R10
      else $error("request asserted during row pulse");
   a_exit_refresh_follows: assert property (@(posedge mclk) disable iff (rst)
      state_ff == ST_SR_EXIT && sq.done |=> state_ff == ST_ORD_REF && sq.start) // R05
      else $error("no strobe-order refresh after self-refresh exit");
   a_no_access_init: assert property (@(posedge mclk) disable iff (rst)
      state_ff inside {ST_PAUSE, ST_INIT} |-> !ready_ff) // R01
      else $error("ready before init complete");
   a_write_strobe_read: assert property (@(posedge mclk) disable iff (rst)
      state_ff == ST_ACCESS |-> writeStrobeN_ff) // R13
      else $error("write strobe low in read access");
   a_enter_via_refresh: assert property (@(posedge mclk) disable iff (rst)
      state_ff == ST_SR_ENTER && sq.done |=> state_ff == ST_SR) // R06
      else $error("self-refresh entry not after strobe-order refresh");
   c_init_done: cover property (@(posedge mclk) $rose(ready_ff));
   c_enter_sr: cover property (@(posedge mclk) $rose(inSelfRefresh_ff));
   c_exit_sr: cover property (@(posedge mclk) $fell(inSelfRefresh_ff));
endmodule

// ===== rtl/strobe_if.sv
// interface: strobe sequencer request and status between host modules
`timescale 1ns/1ps
interface strobe_if;
   import dram_host_pkg::*;
   logic start;
   logic colFirst;
   logic busy;
   logic done;
   modport ctrl (output start, output colFirst, input busy, input done);
   modport seq  (input start, input colFirst, output busy, output done);
endinterface

// ===== rtl/strobe_seq.sv
// module: one row-strobe pulse, optionally with column strobe leading it
`timescale 1ns/1ps
module strobe_seq
   import dram_host_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   strobe_if.seq     req,
   output logic      rowStrobeN_ff,
   output logic      colStrobeN_ff
);
   phase_type             phase_ff;
   logic [CNT_W-1:0]      cnt_ff;
   logic                  colMode_ff;

   // -----------------------------------------------
   // pulse sequencer
   // -----------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_ff      <= PH_IDLE;
         cnt_ff        <= '0;
         colMode_ff    <= 1'b0;
         rowStrobeN_ff <= 1'b1;
         colStrobeN_ff <= 1'b1;
         req.done      <= 1'b0;
      end else begin
         req.done <= 1'b0;
         unique case (phase_ff)
            PH_IDLE: begin
               if (req.start) begin
                  colMode_ff <= req.colFirst;
                  cnt_ff     <= '0;
                  if (req.colFirst) begin
                     colStrobeN_ff <= 1'b0; // R11
                     phase_ff      <= PH_LEAD;
                  end else begin
                     rowStrobeN_ff <= 1'b0;
                     phase_ff      <= PH_LOW;
                  end
               end
            end
            PH_LEAD: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == CNT_W'(COL_SETUP_CYC - 1)) begin
                  rowStrobeN_ff <= 1'b0; // R11
                  cnt_ff        <= '0;
                  phase_ff      <= PH_LOW;
               end
            end
            PH_LOW: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == CNT_W'(PULSE_CYC - 1)) begin
                  rowStrobeN_ff <= 1'b1;
                  colStrobeN_ff <= 1'b1;
                  cnt_ff        <= '0;
                  phase_ff      <= PH_HIGH;
               end
            end
            PH_HIGH: begin
               cnt_ff <= cnt_ff + 1'b1;
               // precharge padded so pulse+precharge meets the 1000 ns minimum cycle
               if (cnt_ff == CNT_W'(SR_PERIOD_CYC - PULSE_CYC - 1)) begin // R08
                  req.done <= 1'b1;
                  phase_ff <= PH_IDLE;
               end
            end
         endcase
      end
   end

   assign req.busy = (phase_ff != PH_IDLE);

   // -----------------------------------------------
   // checks
   // -----------------------------------------------
   a_col_leads_row: assert property (@(posedge mclk) disable iff (rst)
      $fell(rowStrobeN_ff) && colMode_ff |-> !colStrobeN_ff) // R11
      else $error("column strobe not low before row strobe fell");
   a_row_low_width: assert property (@(posedge mclk) disable iff (rst)
      $fell(rowStrobeN_ff) |-> !rowStrobeN_ff [*8]) // R08
      else $error("row strobe pulse too short");
endmodule

// ===== tb/dram_device_model.sv
// partner model: refresh side of the dram, internal row counter and cycle decoding
`timescale 1ns/1ps
module dram_device_model
   import dram_host_pkg::*;
(
   input  wire logic        rowStrobeN,
   input  wire logic        colStrobeN,
   input  wire logic        self_refresh_request_n,
   input  wire logic        writeStrobeN,
   output logic [ROW_W-1:0] refreshRow,
   output int               refreshes,
   output logic             lastWrite,
   output int               earlyWrites
);
   // -----------------------------------------------
   // power-up state
   // -----------------------------------------------
   initial begin
      refreshRow = '0;
      refreshes  = 0;
      lastWrite  = 1'h0;
      earlyWrites = 0;
   end
   // early write: data is taken at the column strobe fall, not at the write strobe
   always @(negedge colStrobeN) begin
      if (rowStrobeN === 1'h0 && writeStrobeN === 1'h0) earlyWrites = earlyWrites + 1;
   end
   // -----------------------------------------------
   // cycle decode at each row strobe fall
   // -----------------------------------------------
   // no clock in the device: only the order of strobe edges matters
   always @(negedge rowStrobeN) begin
      lastWrite = (writeStrobeN === 1'h0);
      // column low before row falls, or request low: counter supplies the row
      if (colStrobeN === 1'h0 || self_refresh_request_n === 1'h0) begin
         refreshRow = refreshRow + 9'h1;
         refreshes  = refreshes + 1;
      end
   end
endmodule

// ===== tb/tb_dram_refresh_host.sv
// testbench: power-up, refresh spacing and self-refresh of the refresh host
`timescale 1ns/1ps
module tb_dram_refresh_host;
   import dram_host_pkg::*;
   logic mclk, rst, selfRefreshReq, accessReq;
   logic rowStrobeN_ff, colStrobeN_ff, self_refresh_request_n_ff, writeStrobeN_ff;
   logic ready_ff, inSelfRefresh_ff, lastWrite;
   logic [ROW_W-1:0] refreshRow_ff, modelRow;
   int   refreshes, errors, n_checks, cyc, lastOrdRef, lastSr, lastKind, initFalls, base;
   int   earlyWrites;
   int   seed = 32'h68d705b5;
   logic rowPrev, inPrev, readySeen;
   logic srExpQ[$];
   // -----------------------------------------------
   // clock, design and partner
   // -----------------------------------------------
   initial mclk = 1'h0;
   always #12.5 mclk = ~mclk;
   dram_refresh_host dut (.mclk(mclk), .rst(rst), .selfRefreshReq(selfRefreshReq),
      .accessReq(accessReq), .rowStrobeN_ff(rowStrobeN_ff), .colStrobeN_ff(colStrobeN_ff),
      .self_refresh_request_n_ff(self_refresh_request_n_ff),
      .writeStrobeN_ff(writeStrobeN_ff), .ready_ff(ready_ff),
      .inSelfRefresh_ff(inSelfRefresh_ff), .refreshRow_ff(refreshRow_ff));
   dram_device_model mem (.rowStrobeN(rowStrobeN_ff), .colStrobeN(colStrobeN_ff),
      .self_refresh_request_n(self_refresh_request_n_ff), .writeStrobeN(writeStrobeN_ff),
      .refreshRow(modelRow), .refreshes(refreshes), .lastWrite(lastWrite),
      .earlyWrites(earlyWrites));
   // -----------------------------------------------
   // shared tasks
   // -----------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic waitReady(input int limit);
      int i;
      for (i = 0; i < limit && ready_ff !== 1'h1; i++) @(negedge mclk);
      if (ready_ff !== 1'h1) begin
         errors++;
         $display("unexpected at %0t: ready never came", $time);
         report_and_stop();
      end
   endtask
   // -----------------------------------------------
   // watcher: strobe timing and queued mode results
   // -----------------------------------------------
   // times are counted in clock cycles from reset release
   always @(posedge mclk) begin
      if (rst) begin
         cyc = 0; lastOrdRef = -1; lastSr = 0; lastKind = 0; initFalls = 0;
         readySeen = 1'h0; inPrev = 1'h0;
      end else begin
         cyc++;
         if (cyc < POWERUP_CYC && {rowStrobeN_ff, colStrobeN_ff,
             self_refresh_request_n_ff} !== 3'h7) check(0, 1);
         if (ready_ff === 1'h1) readySeen = 1'h1;
         if (rowPrev === 1'h1 && rowStrobeN_ff === 1'h0) begin
            check(writeStrobeN_ff, 1'h1);
            if (!readySeen) initFalls++;
            if (self_refresh_request_n_ff === 1'h0) begin
               if (lastKind == 2) check(cyc - lastSr >= SR_PERIOD_CYC, 1);
               if (lastKind == 2) check(cyc - lastSr <= SR_PERIOD_MAX_CYC, 1);
               if (lastKind == 1) check(cyc - lastOrdRef <= SR_PERIOD_MAX_CYC, 1);
               lastSr = cyc;
               lastKind = 2;
            end else if (colStrobeN_ff === 1'h0) begin
               if (lastKind == 2) check(cyc - lastSr <= SR_PERIOD_MAX_CYC, 1);
               else if (lastOrdRef >= 0) check(cyc - lastOrdRef <= REFRESH_CYC, 1);
               lastOrdRef = cyc;
               lastKind = 1;
            end
         end
         if (inSelfRefresh_ff !== inPrev) begin
            if (srExpQ.size() == 0) check(inSelfRefresh_ff, inPrev);
            else check(inSelfRefresh_ff, srExpQ.pop_front());
         end
         inPrev = inSelfRefresh_ff;
      end
      rowPrev = rowStrobeN_ff;
   end
   // -----------------------------------------------
   // main sequence
   // -----------------------------------------------
   task automatic selfRefresh(input int hold);
      @(negedge mclk);
      selfRefreshReq = 1'h1;
      srExpQ.push_back(1'h1);
      repeat (hold) @(negedge mclk);
      selfRefreshReq = 1'h0;
      srExpQ.push_back(1'h0);
      repeat (4) @(negedge mclk);
      waitReady(2000);
      check(refreshRow_ff, modelRow);
   endtask
   initial begin
      int i;
      rst = 1'h1; selfRefreshReq = 1'h0; accessReq = 1'h0;
      rowPrev = 1'h1; errors = 0; n_checks = 0;
      repeat (4) @(negedge mclk);
      rst = 1'h0;
      waitReady(POWERUP_CYC + 1000);
      check(initFalls, INIT_STROBES);
      check(refreshRow_ff, modelRow);
      $display("test power-up done");
      // random reads, on average long enough that one forced refresh lands among them
      for (i = 0; i < 120; i++) begin
         accessReq = 1'($random(seed) & 32'h1);
         repeat (1 + ($random(seed) & 32'h3f)) @(negedge mclk);
      end
      accessReq = 1'h0;
      waitReady(2000);
      check(refreshRow_ff, modelRow);
      check(lastWrite, 1'h0);
      check(earlyWrites, 0);
      $display("test reads and refresh done");
      // long stay: more pulses than rows, so the counter wraps
      base = refreshes;
      selfRefresh(30000);
      check(refreshes - base >= ROW_COUNT, 1);
      $display("test long self-refresh done");
      // short normal gap between two self-refresh periods
      repeat (10) @(negedge mclk);
      selfRefresh(600);
      $display("test back-to-back self-refresh done");
      report_and_stop();
   end
   initial begin
      #2ms;
      errors++;
      $display("unexpected at %0t: run limit reached", $time);
      report_and_stop();
   end
endmodule
